// [logic/ulf_cfg.svh]
// Purpose: Offsets, field positions and reset values for the LPM flag block
// Assumes: 32-bit AXI4-Lite register bus, word aligned
// Notes: Definitions only
`ifndef ULF_CFG_SVH
`define ULF_CFG_SVH
`define ULF_OFF_CONTROL_TWO 4'h0
`define ULF_OFF_MASK 4'h4
`define ULF_OFF_MODE 4'h8
`define ULF_ADDR_LSB 8
`define ULF_ADDR_MSB 14
`define ULF_BIT_ERR 5
`define ULF_BIT_RES 4
`define ULF_BIT_NC 3
`define ULF_BIT_ACK 2
`define ULF_BIT_NY 1
`define ULF_BIT_ST 0
`define ULF_FLAGS_RST 6'h00
`define ULF_ADDR_RST 7'h00
`define ULF_RESP_OKAY 2'h0
`define ULF_RESP_SLVERR 2'h2
`endif

// [logic/ulf_pkg.sv]
// Purpose: Types for the LPM flag block
// Assumes: Nothing beyond the config header
// Notes: Reply codes seen on the LPM event port
package ulf_pkg;
    typedef enum logic [1:0] {
        ULF_REPLY_ACK = 2'b00,
        ULF_REPLY_NYET = 2'b01,
        ULF_REPLY_STALL = 2'b10,
        ULF_REPLY_NONE = 2'b11
    } ulf_reply_t;
    typedef enum logic [1:0] {
        ULF_WR_IDLE = 2'b00,
        ULF_WR_RESP = 2'b01
    } ulf_wr_state_t;
endpackage

// [logic/ulf_flag_reg.sv]
// Purpose: Bank of sticky flags, set by hardware, cleared by a read
// Assumes: Set and clear are single-cycle pulses
// Notes: A set in the clearing cycle wins
`timescale 1ns/100ps
module ulf_flag_reg #(
    parameter int WIDTH = 6
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [WIDTH-1:0] set_i,
    input wire logic clear_i,
    output logic [WIDTH-1:0] flags_o
);
    // Set beats clear so no event is lost at the read edge
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            flags_o <= '0;
        end else begin
            flags_o <= set_i | (clear_i ? '0 : flags_o);
        end
    end
endmodule

// [logic/ulf_lpm_flags.sv]
// Contract
// - Seven-bit read/write function address in bits 14:8, reset zero.
// - Device mode: unsupported link state gets STALL and sets error flag bit 5.
// - Any resume from low power sets resume flag bit 4.
// - Device mode: NYET due to pending RX data sets not-complete bit 3.
// - Host mode: ACK reply to a sent LPM sets not-complete bit 3.
// - Device mode: received LPM answered ACK sets acknowledge bit 2.
// - Host mode: ACK reply to sent LPM sets acknowledge bit 2.
// - Device mode: received LPM answered NYET sets not-yet bit 1.
// - Host mode: NYET reply to sent LPM sets not-yet bit 1.
// - Bits 31:15 and 7:6 read zero; flags read-only, hardware set, reset zero.
//
// Purpose: LPM outcome flags and payload function address behind AXI4-Lite
// Assumes: Event inputs are one-cycle pulses synchronous to clk_i
// Notes: Reading the control register clears the flags
`timescale 1ns/100ps
`include "ulf_cfg.svh"
module ulf_lpm_flags #(
    parameter int ADDR_W = 4
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic host_mode_i,
    input wire logic lpm_event_i,
    input wire logic [1:0] lpm_reply_i,
    input wire logic link_state_bad_i,
    input wire logic rx_pending_i,
    input wire logic resume_i,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic lpm_stall_o,
    output logic irq_o
);

////////////////////////////////////////////////////////////////////////////////
    // Register state
    logic [6:0] lpm_function_address;
    logic [5:0] flag_mask;
    logic [5:0] flags;
    logic [5:0] next_set;
    logic read_clear;
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

////////////////////////////////////////////////////////////////////////////////
    // Event decode; a bad link state forces a STALL reply in device mode
    wire dev_ev = lpm_event_i & ~host_mode_i;
    wire host_ev = lpm_event_i & host_mode_i;
    wire is_ack = lpm_reply_i == ulf_pkg::ULF_REPLY_ACK;
    wire is_nyet = lpm_reply_i == ulf_pkg::ULF_REPLY_NYET;
    wire is_stall = lpm_reply_i == ulf_pkg::ULF_REPLY_STALL;
    wire dev_bad = dev_ev & link_state_bad_i;
    wire set_err = dev_bad;
    wire set_res = resume_i;
    wire set_nc = (dev_ev & ~dev_bad & is_nyet & rx_pending_i)
        | (host_ev & is_ack);
    wire set_ack = (dev_ev & ~dev_bad & is_ack)
        | (host_ev & is_ack);
    wire set_ny = (dev_ev & ~dev_bad & is_nyet)
        | (host_ev & is_nyet);
    wire set_st = lpm_event_i & (is_stall | dev_bad);

    // Gather set pulses in field order
    always_comb begin
        next_set = '0;
        next_set[`ULF_BIT_ERR] = set_err;
        next_set[`ULF_BIT_RES] = set_res;
        next_set[`ULF_BIT_NC] = set_nc;
        next_set[`ULF_BIT_ACK] = set_ack;
        next_set[`ULF_BIT_NY] = set_ny;
        next_set[`ULF_BIT_ST] = set_st;
    end

    // Flags are hardware set only; software can just read and thereby clear
    ulf_flag_reg #(
        .WIDTH(6)
    ) u_flags (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .set_i(next_set),
        .clear_i(read_clear),
        .flags_o(flags)
    );

    // STALL answer toward the link, registered
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            lpm_stall_o <= 1'b0;
        end else begin
            lpm_stall_o <= dev_bad | (dev_ev & is_stall);
        end
    end

////////////////////////////////////////////////////////////////////////////////
    // Write channel: address and data may come in either order
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire have_aw = aw_held | aw_take;
    wire have_w = w_held | w_take;
    wire [ADDR_W-1:0] wr_addr = aw_take ? s_axi_awaddr : aw_addr;
    wire [31:0] wr_data = w_take ? s_axi_wdata : w_data;
    wire [3:0] wr_strb = w_take ? s_axi_wstrb : w_strb;
    wire wr_fire = have_aw & have_w & ~s_axi_bvalid;
    wire wr_ctl = wr_addr == ADDR_W'(`ULF_OFF_CONTROL_TWO);
    wire wr_msk = wr_addr == ADDR_W'(`ULF_OFF_MASK);
    wire wr_mode = wr_addr == ADDR_W'(`ULF_OFF_MODE);
    wire wr_ok = wr_ctl | wr_msk | wr_mode;

    // Capture halves and answer once both are here
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ULF_RESP_OKAY;
        end else begin
            s_axi_awready <= ~have_aw & ~s_axi_bvalid & ~wr_fire;
            s_axi_wready <= ~have_w & ~s_axi_bvalid & ~wr_fire;
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? `ULF_RESP_OKAY : `ULF_RESP_SLVERR;
            end else begin
                if (aw_take) begin
                    aw_held <= 1'b1;
                    aw_addr <= s_axi_awaddr;
                end
                if (w_take) begin
                    w_held <= 1'b1;
                    w_data <= s_axi_wdata;
                    w_strb <= s_axi_wstrb;
                end
                if (s_axi_bvalid & s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                end
            end
        end
    end

    // Software fields; flags ignore writes
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            lpm_function_address <= `ULF_ADDR_RST;
            flag_mask <= `ULF_FLAGS_RST;
        end else if (wr_fire) begin
            if (wr_ctl & wr_strb[1]) begin
                lpm_function_address <= wr_data[`ULF_ADDR_MSB:`ULF_ADDR_LSB];
            end
            if (wr_msk & wr_strb[0]) begin
                flag_mask <= wr_data[5:0];
            end
        end
    end

////////////////////////////////////////////////////////////////////////////////
    // Read channel; one read at a time, data registered
    wire ar_take = s_axi_arvalid & s_axi_arready;
    wire rd_ctl = s_axi_araddr == ADDR_W'(`ULF_OFF_CONTROL_TWO);
    wire rd_msk = s_axi_araddr == ADDR_W'(`ULF_OFF_MASK);
    wire rd_mode = s_axi_araddr == ADDR_W'(`ULF_OFF_MODE);
    // Unused bits 31:15 and 7:6 are zero by construction
    wire [31:0] ctl_word = {17'h00000, lpm_function_address, 2'h0, flags};
    wire [31:0] rd_word = rd_ctl ? ctl_word :
        rd_msk ? {26'h0000000, flag_mask} :
        rd_mode ? {31'h00000000, host_mode_i} : 32'h00000000;
    assign read_clear = ar_take & rd_ctl;

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `ULF_RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~ar_take;
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= (rd_ctl | rd_msk | rd_mode) ? `ULF_RESP_OKAY
                    : `ULF_RESP_SLVERR;
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

////////////////////////////////////////////////////////////////////////////////
    // Level interrupt from unmasked sticky flags
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(flags & flag_mask);
        end
    end

////////////////////////////////////////////////////////////////////////////////
    // Checks
    // Reset is looked at forward from a sampled reset, so the very first edge of the run,
    // which has no history, can never trip these
    a_addr_reset: assert property (@(posedge clk_i) sys_rst_i |=>
        lpm_function_address == 7'h00) else $error("address not reset");
    a_flag_reset: assert property (@(posedge clk_i) sys_rst_i |=>
        flags == 6'h00 && !irq_o && !lpm_stall_o) else $error("flags or outputs not reset");
    a_bus_reset: assert property (@(posedge clk_i) sys_rst_i |=>
        !s_axi_bvalid && !s_axi_rvalid) else $error("bus answer during reset");

    // Function address only moves on a strobed write of the control register
    a_addr_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wr_fire & wr_ctl & wr_strb[1] |=> lpm_function_address == $past(wr_data[14:8]))
        else $error("address write lost");
    a_addr_keep: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !(wr_fire & wr_ctl & wr_strb[1]) |=> $stable(lpm_function_address))
        else $error("address changed without write");
    a_mask_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wr_fire & wr_msk & wr_strb[0] |=> flag_mask == $past(wr_data[5:0]))
        else $error("mask write lost");
    a_mask_keep: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !(wr_fire & wr_msk & wr_strb[0]) |=> $stable(flag_mask))
        else $error("mask changed without write");

    // Bus answers: one cycle after the request, held until taken
    a_b_after: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wr_fire |=> s_axi_bvalid) else $error("write answer late");
    a_r_after: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ar_take |=> s_axi_rvalid) else $error("read answer late");
    a_okay_wr: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wr_fire & wr_ok |=> s_axi_bresp == `ULF_RESP_OKAY)
        else $error("mapped write refused");
    a_slverr_wr: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        wr_fire & !wr_ok |=> s_axi_bresp == `ULF_RESP_SLVERR)
        else $error("unmapped write accepted");
    a_rresp_err: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ar_take & !(rd_ctl | rd_msk | rd_mode) |=>
        s_axi_rresp == `ULF_RESP_SLVERR && s_axi_rdata == 32'h00000000)
        else $error("unmapped read accepted");
    a_mode_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ar_take & rd_mode |=> s_axi_rdata == {31'h00000000, $past(host_mode_i)})
        else $error("mode readback wrong");
    a_bvalid_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        s_axi_bvalid & !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    a_rvalid_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        s_axi_rvalid & !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");

    // No new request is taken while an answer is still pending
    a_aw_block: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during answer");
    a_ar_block: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        s_axi_rvalid |-> !s_axi_arready) else $error("read taken during answer");
    a_aw_idle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        s_axi_awready & !s_axi_awvalid & !s_axi_bvalid |=> s_axi_awready)
        else $error("idle write ready dropped");
    a_ar_idle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        s_axi_arready & !s_axi_arvalid |=> s_axi_arready)
        else $error("idle read ready dropped");

    // Read of the control register shows the flags before they clear
    a_rdata_pre: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ar_take & rd_ctl |=> s_axi_rdata[5:0] == $past(flags))
        else $error("flag readback wrong");
    a_clear_read: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        read_clear && next_set == 6'h00 |=> flags == 6'h00)
        else $error("flags not cleared by read");
    a_irq_level: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        1'b1 |=> irq_o == $past(|(flags & flag_mask)))
        else $error("interrupt level wrong");

    // STALL answer and error flag belong to device mode only
    a_stall_pulse: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        lpm_stall_o |-> $past(dev_ev)) else $error("stall without device event");
    a_host_no_err: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        host_ev |-> !next_set[5]) else $error("error flag in host mode");
    a_bad_quiet: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        dev_bad |-> next_set[3:1] == 3'h0) else $error("bad link state set outcome");

    // Outcome flags, one per rule
    a_err_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        dev_ev & link_state_bad_i & ~read_clear |=> flags[5] & lpm_stall_o)
        else $error("error flag or stall missing");
    a_res_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        resume_i |=> flags[4]) else $error("resume flag missing");
    a_nc_dev: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        dev_ev & ~link_state_bad_i & is_nyet & rx_pending_i |=> flags[3] & flags[1])
        else $error("device nc or nyet missing");
    a_nc_host: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        host_ev & is_ack |=> flags[3] & flags[2])
        else $error("host nc or ack missing");
    a_ack_dev: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        dev_ev & ~link_state_bad_i & is_ack |=> flags[2] & ~$past(next_set[3]))
        else $error("device ack wrong");
    a_ack_host: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        host_ev & is_ack |=> flags[2] & ~$past(next_set[1]))
        else $error("host ack wrong");
    a_ny_dev: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        dev_ev & ~link_state_bad_i & is_nyet |=> flags[1])
        else $error("device nyet missing");
    a_ny_host: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        host_ev & is_nyet |=> flags[1]) else $error("host nyet missing");
    a_zero_bits: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        s_axi_rvalid |-> s_axi_rdata[31:15] == 17'h00000 &&
        (s_axi_rdata[7:6] == 2'h0)) else $error("unused bits not zero");
    a_flag_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        next_set == 6'h00 && !read_clear |=> flags == $past(flags))
        else $error("flag changed without cause");
    a_stall_flag: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        lpm_event_i & is_stall |=> flags[0]) else $error("stall flag missing");
endmodule

// [sim/ulf_peer_model.sv]
// Purpose: USB peer that completes LPM transactions for the flag block
// Assumes: One completion per call, host mode held by the bench
// Notes: Qualifiers scramble when idle so a stale reply never looks valid
`timescale 1ns/100ps
module ulf_peer_model (
    input wire logic clk_i,
    output logic lpm_event_o,
    output logic [1:0] lpm_reply_o,
    output logic link_state_bad_o,
    output logic rx_pending_o,
    output logic resume_o
);
    // Idle levels at time zero
    initial begin
        lpm_event_o = 1'b0;
        lpm_reply_o = 2'h3;
        link_state_bad_o = 1'b0;
        rx_pending_o = 1'b0;
        resume_o = 1'b0;
    end
    // One-cycle completion or resume, then inverted qualifiers
    task automatic send(input logic [1:0] rep, input logic bad, input logic pend,
                        input logic res);
        lpm_event_o <= ~res;
        resume_o <= res;
        lpm_reply_o <= rep;
        link_state_bad_o <= bad;
        rx_pending_o <= pend;
        @(posedge clk_i);
        lpm_event_o <= 1'b0;
        resume_o <= 1'b0;
        lpm_reply_o <= ~rep;
        link_state_bad_o <= ~bad;
        rx_pending_o <= ~pend;
    endtask
endmodule

// [sim/ulf_lpm_flags_test.sv]
// Purpose: Self-checking bench for the LPM flag block
// Assumes: Peer model drives the USB side, bench is the bus master
// Notes: Responses are compared with notes kept in queues
`timescale 1ns/100ps
`include "ulf_cfg.svh"
module ulf_lpm_flags_test;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic host_mode = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, lpm_event, bad, pend, resume, stall, irq;
    logic [1:0] bresp, rresp, reply;
    logic [31:0] rdata;
    logic [6:0] fa = 7'h00;
    logic [6:0] rnd;
    logic [1:0] exp_b[$], exp_rr[$];
    logic [31:0] exp_r[$];
    int failures = 0, samples_checked = 0;

    always #5 clk_i = ~clk_i;

    ulf_lpm_flags u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .host_mode_i(host_mode),
        .lpm_event_i(lpm_event), .lpm_reply_i(reply), .link_state_bad_i(bad),
        .rx_pending_i(pend), .resume_i(resume), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .lpm_stall_o(stall), .irq_o(irq));
    ulf_peer_model u_peer (.clk_i(clk_i), .lpm_event_o(lpm_event), .lpm_reply_o(reply),
        .link_state_bad_o(bad), .rx_pending_o(pend), .resume_o(resume));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic stop_test;
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    function automatic logic [31:0] ctl(input logic [5:0] f);
        return {17'h0, fa, 2'b00, f};
    endfunction

    // Write: both halves offered together, each dropped when taken
    task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                       input logic [1:0] r);
        exp_b.push_back(r);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk_i);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) bready <= 1'b0;
        end while (awvalid || wvalid || bready);
    endtask

    task automatic axr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        exp_r.push_back(d);
        exp_rr.push_back(r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk_i);
            if (arready) arvalid <= 1'b0;
            if (rvalid) rready <= 1'b0;
        end while (arvalid || rready);
    endtask

    // Scoreboard: oldest note against each response at its handshake
    always @(posedge clk_i) begin
        if (bvalid && bready)
            chk({30'h0, bresp}, {30'h0, exp_b.pop_front()}, "bresp");
        if (rvalid && rready) begin
            chk(rdata, exp_r.pop_front(), "rdata");
            chk({30'h0, rresp}, {30'h0, exp_rr.pop_front()}, "rresp");
        end
    end

    // One transaction outcome, then readback and clear-on-read
    task automatic run_case(input logic h, input logic [1:0] rep, input logic b,
                            input logic p, input logic rs, input logic [5:0] f,
                            input logic st);
        host_mode <= h;
        @(posedge clk_i);
        u_peer.send(rep, b, p, rs);
        @(posedge clk_i);
        chk({31'h0, stall}, {31'h0, st}, "stall");
        axr(`ULF_OFF_MODE, {31'h0, h}, `ULF_RESP_OKAY);
        axr(`ULF_OFF_CONTROL_TWO, ctl(f), `ULF_RESP_OKAY);
        axr(`ULF_OFF_CONTROL_TWO, ctl(6'h00), `ULF_RESP_OKAY);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(32'had1aacf7));
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        axr(`ULF_OFF_CONTROL_TWO, 32'h0, `ULF_RESP_OKAY);
        axr(`ULF_OFF_MASK, 32'h0, `ULF_RESP_OKAY);
        axw(`ULF_OFF_CONTROL_TWO, 32'hFFFF_FFFF, 4'hF, `ULF_RESP_OKAY);
        fa = 7'h7F;
        axr(`ULF_OFF_CONTROL_TWO, ctl(6'h00), `ULF_RESP_OKAY);
        rnd = 7'($urandom);
        axw(`ULF_OFF_CONTROL_TWO, {17'h0, ~rnd, 8'h00}, 4'h1, `ULF_RESP_OKAY);
        axr(`ULF_OFF_CONTROL_TWO, ctl(6'h00), `ULF_RESP_OKAY);
        axw(`ULF_OFF_CONTROL_TWO, {17'h0, rnd, 8'hFF}, 4'h2, `ULF_RESP_OKAY);
        fa = rnd;
        axr(`ULF_OFF_CONTROL_TWO, ctl(6'h00), `ULF_RESP_OKAY);
        run_case(1'b0, ulf_pkg::ULF_REPLY_ACK, 1'b0, 1'b0, 1'b0, 6'h04, 1'b0);
        run_case(1'b0, ulf_pkg::ULF_REPLY_NYET, 1'b0, 1'b0, 1'b0, 6'h02, 1'b0);
        run_case(1'b0, ulf_pkg::ULF_REPLY_NYET, 1'b0, 1'b1, 1'b0, 6'h0A, 1'b0);
        run_case(1'b0, ulf_pkg::ULF_REPLY_ACK, 1'b1, 1'b0, 1'b0, 6'h21, 1'b1);
        run_case(1'b0, ulf_pkg::ULF_REPLY_STALL, 1'b0, 1'b0, 1'b0, 6'h01, 1'b1);
        run_case(1'b1, ulf_pkg::ULF_REPLY_ACK, 1'b0, 1'b0, 1'b0, 6'h0C, 1'b0);
        run_case(1'b1, ulf_pkg::ULF_REPLY_NYET, 1'b0, 1'b1, 1'b0, 6'h02, 1'b0);
        run_case(1'b1, ulf_pkg::ULF_REPLY_STALL, 1'b0, 1'b0, 1'b0, 6'h01, 1'b0);
        run_case(1'b0, ulf_pkg::ULF_REPLY_NONE, 1'b0, 1'b0, 1'b1, 6'h10, 1'b0);
        // Interrupt raised, cleared by read, then masked
        axw(`ULF_OFF_MASK, 32'hFFFF_FFFF, 4'hF, `ULF_RESP_OKAY);
        axr(`ULF_OFF_MASK, 32'h3F, `ULF_RESP_OKAY);
        u_peer.send(ulf_pkg::ULF_REPLY_ACK, 1'b0, 1'b0, 1'b0);
        repeat (3) @(posedge clk_i);
        chk({31'h0, irq}, 32'h1, "irq set");
        axr(`ULF_OFF_CONTROL_TWO, ctl(6'h04), `ULF_RESP_OKAY);
        repeat (3) @(posedge clk_i);
        chk({31'h0, irq}, 32'h0, "irq clear");
        axw(`ULF_OFF_MASK, 32'h02, 4'hF, `ULF_RESP_OKAY);
        u_peer.send(ulf_pkg::ULF_REPLY_ACK, 1'b0, 1'b1, 1'b0);
        repeat (3) @(posedge clk_i);
        chk({31'h0, irq}, 32'h0, "irq masked");
        axr(`ULF_OFF_CONTROL_TWO, ctl(6'h04), `ULF_RESP_OKAY);
        // Unmapped place refuses and changes nothing
        axw(4'hC, 32'hFFFF_FFFF, 4'hF, `ULF_RESP_SLVERR);
        axr(4'hC, 32'h0, `ULF_RESP_SLVERR);
        axr(`ULF_OFF_MASK, 32'h02, `ULF_RESP_OKAY);
        axr(`ULF_OFF_CONTROL_TWO, ctl(6'h00), `ULF_RESP_OKAY);
        stop_test();
    end

    // Watchdog well beyond the roughly 150 cycles of the run
    initial begin
        #200000;
        failures++;
        stop_test();
    end
endmodule
